// ==== adc_sck_out.v ====
// Functional notes
// - Power-up interval ends after about 0.5ms; SCK level then picks mode
// - Weak SCK pull-up in power-up; undriven SCK selects internal mode
// - SCK held low at selection picks external clock mode instead
// - While converting, SCK and SDO are both held high
// - Conversion done drives SCK and SDO low, then device sleeps
// - Sleep lasts at least half an SCK period, then frame starts
// - Frame starts at first SCK rise and ends after the 32nd rise
// - SDO changes on each SCK falling edge during the frame
// - Internal serial clock is driven out on the SCK pin
// - After 32nd rise SDO goes high and SCK stays high while converting
// - In autostart, weak pull-up holds chip select high while converting
// - In autostart, done starts sleep and chip select current sink
// - In autostart, chip select below threshold starts the output frame
// - Autostart: after 32nd rise, chip select pulled high, new conversion
// - Crossing keeps internal mode if SCK reads high, picks external if low; SCK pull-up during discharge
// - Done flag falling loads result into static shift register
`timescale 1ns/1ns
`default_nettype none
`include "adc_sck_out_map.vh"

module adc_sck_out #(
  parameter [23:0] POR_CYCLES = `POR_CYCLES,
  parameter [7:0]  SCK_HALF   = `SCK_HALF_CYCLES
) (
  input  wire                    clk,
  input  wire                    rst,
  input  wire                    ce,
  input  wire                    sck_i,
  output reg                     sck_o,
  output reg                     sck_oe,
  output reg                     sck_pullup_en,
  output reg                     sdo_o,
  input  wire                    cs_low_i,
  output reg                     cs_pullup_en,
  output reg                     cs_sink_en,
  output reg                     conv_start,
  input  wire                    conv_done,
  input  wire [`RESULT_BITS-1:0] conv_word,
  output reg                     ext_mode,
  output reg                     frame_busy
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [4:0] ST_POR   = 5'b00001;
  localparam [4:0] ST_CONV  = 5'b00010;
  localparam [4:0] ST_SLEEP = 5'b00100;
  localparam [4:0] ST_SHIFT = 5'b01000;
  localparam [4:0] ST_EXT   = 5'b10000;

  localparam [5:0] LAST_RISE = 6'd`FRAME_MSB;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg sck_m_q;
  reg sck_s_q;
  reg cs_m_q;
  reg cs_s_q;

  // Idle levels after reset match the pins, so no false edge follows
  always @(posedge clk) begin
    if (rst) begin
      sck_m_q <= 1'b1;
      sck_s_q <= 1'b1;
      cs_m_q  <= 1'b0;
      cs_s_q  <= 1'b0;
    end else if (ce) begin
      sck_m_q <= sck_i;
      sck_s_q <= sck_m_q;
      cs_m_q  <= cs_low_i;
      cs_s_q  <= cs_m_q;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  reg [4:0]            state_q;
  reg [4:0]            state_d;
  reg [23:0]           por_cnt_q;
  reg [7:0]            tmr_q;
  reg [5:0]            rise_cnt_q;
  reg [`FRAME_BITS-1:0] shift_q;
  reg                  cs_was_hi_q;

  wire half_done;
  wire por_done;

  assign half_done = (tmr_q == SCK_HALF - 8'd1);
  assign por_done  = (por_cnt_q == POR_CYCLES - 24'd1);

  // ----------------------------------------------------------------
  // Shared decoding
  // ----------------------------------------------------------------
  // Chip select crossed while SCK reads low: internal mode is lost
  function mode_lost;
    input cs_low;
    input was_hi;
    input sck_hi;
    begin
      mode_lost = cs_low & was_hi & ~sck_hi;
    end
  endfunction

  // Chip select below threshold and minimum sleep served
  function frame_go;
    input cs_low;
    input half;
    begin
      frame_go = cs_low & half;
    end
  endfunction

  // Low half before the 32nd rise has run out
  function frame_last;
    input       half;
    input       sck_hi;
    input [5:0] rises;
    begin
      frame_last = half & ~sck_hi & (rises == LAST_RISE);
    end
  endfunction

  // Half-period timer step
  function [7:0] tmr_step;
    input [7:0] t;
    begin
      tmr_step = t + 8'h01;
    end
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_POR: begin
        if (por_done) begin
          if (sck_s_q) begin
            state_d = ST_CONV;
          end else begin
            state_d = ST_EXT;
          end
        end
      end
      ST_CONV: begin
        if (conv_done) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (mode_lost(cs_s_q, cs_was_hi_q, sck_s_q)) begin
          state_d = ST_EXT;
        end else if (frame_go(cs_s_q, half_done)) begin
          state_d = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (frame_last(half_done, sck_o, rise_cnt_q)) begin
          state_d = ST_CONV;
        end
      end
      ST_EXT: begin
        state_d = ST_EXT;
      end
      default: begin
        state_d = ST_POR;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers and pin drive
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      state_q       <= ST_POR;
      por_cnt_q     <= 24'd0;
      tmr_q         <= 8'd0;
      rise_cnt_q    <= 6'd0;
      shift_q       <= `RST_SHIFT;
      cs_was_hi_q   <= 1'b0;
      sck_o         <= `RST_SCK;
      sck_oe        <= 1'b0;
      sck_pullup_en <= 1'b1;
      sdo_o         <= `RST_SDO;
      cs_pullup_en  <= 1'b0;
      cs_sink_en    <= 1'b0;
      conv_start    <= 1'b0;
      ext_mode      <= 1'b0;
      frame_busy    <= 1'b0;
    end else if (ce) begin
      state_q    <= state_d;
      conv_start <= 1'b0;
      case (state_q)
        ST_POR: begin
          // Weak pull-up on SCK while the power-up interval runs
          sck_oe        <= 1'b0;
          sck_pullup_en <= 1'b1;
          por_cnt_q     <= por_cnt_q + 24'd1;
          if (por_done) begin
            if (sck_s_q) begin
              sck_o         <= 1'b1;
              sck_oe        <= 1'b1;
              sck_pullup_en <= 1'b0;
              sdo_o         <= 1'b1;
              cs_pullup_en  <= 1'b1;
              conv_start    <= 1'b1;
            end else begin
              sck_pullup_en <= 1'b0;
              ext_mode      <= 1'b1;
            end
          end
        end
        ST_CONV: begin
          sck_o        <= 1'b1;
          sck_oe       <= 1'b1;
          sdo_o        <= 1'b1;
          cs_pullup_en <= 1'b1;
          cs_sink_en   <= 1'b0;
          tmr_q        <= 8'd0;
          cs_was_hi_q  <= 1'b0;
          if (conv_done) begin
            shift_q      <= {1'b0, conv_word};
            sck_o        <= 1'b0;
            sdo_o        <= 1'b0;
            cs_pullup_en <= 1'b0;
            cs_sink_en   <= 1'b1;
          end
        end
        ST_SLEEP: begin
          // Drive SCK low if chip select is low, else let the pull-up hold
          sck_oe        <= cs_s_q;
          sck_pullup_en <= ~cs_s_q;
          if (!cs_s_q) begin
            cs_was_hi_q <= 1'b1;
          end else begin
            // Only the first cycle below threshold re-selects the mode
            cs_was_hi_q <= 1'b0;
          end
          if (!half_done) begin
            tmr_q <= tmr_step(tmr_q);
          end
          if (mode_lost(cs_s_q, cs_was_hi_q, sck_s_q)) begin
            sck_oe        <= 1'b0;
            sck_pullup_en <= 1'b0;
            cs_sink_en    <= 1'b0;
            ext_mode      <= 1'b1;
          end else if (frame_go(cs_s_q, half_done)) begin
            tmr_q         <= 8'd0;
            rise_cnt_q    <= 6'd0;
            sck_oe        <= 1'b1;
            sck_pullup_en <= 1'b0;
            cs_sink_en    <= 1'b0;
            frame_busy    <= 1'b1;
          end
        end
        ST_SHIFT: begin
          if (half_done) begin
            tmr_q <= 8'd0;
            if (!sck_o) begin
              sck_o      <= 1'b1;
              rise_cnt_q <= rise_cnt_q + 6'd1;
              if (frame_last(half_done, sck_o, rise_cnt_q)) begin
                // SDO rises with the last SCK rise; latch on the rise
                sdo_o        <= 1'b1;
                cs_pullup_en <= 1'b1;
                conv_start   <= 1'b1;
                frame_busy   <= 1'b0;
              end
            end else begin
              sck_o   <= 1'b0;
              sdo_o   <= shift_q[`FRAME_MSB-1];
              shift_q <= {shift_q[`FRAME_MSB-1:0], 1'b0};
            end
          end else begin
            tmr_q <= tmr_step(tmr_q);
          end
        end
        ST_EXT: begin
          // External clock modes are outside this block; stay idle
          sck_oe        <= 1'b0;
          sck_pullup_en <= 1'b0;
          ext_mode      <= 1'b1;
          frame_busy    <= 1'b0;
        end
        default: begin
          sck_oe <= 1'b0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ==== adc_sck_out_map.vh ====
`ifndef ADC_SCK_OUT_MAP_VH
`define ADC_SCK_OUT_MAP_VH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS     40
`define POR_TIME_NS       500000
// End of power-up interval: 500 us at 40 ns per cycle
`define POR_CYCLES        24'h00_30d4
// Internal serial clock half period in system clocks
`define SCK_HALF_CYCLES   8'h04

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define FRAME_BITS        32
`define FRAME_MSB         31
`define RESULT_BITS       31
`define DONE_FLAG_BIT     31

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_SCK           1'b0
`define RST_SDO           1'b1
`define RST_SHIFT         32'h0000_0000

`endif

// ==== adc_sck_out_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
module adc_sck_out_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic sck_o,
  input wire logic sck_oe,
  input wire logic sdo_o,
  input wire logic cs_pullup_en,
  input wire logic cs_sink_en,
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic ext_mode,
  input wire logic frame_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic       prev_q;
  logic [5:0] rises_q;
  wire        rise = sck_o & ~prev_q;
  // Counts clock rises since the last result
  always @(posedge clk) begin
    prev_q  <= sck_o;
    rises_q <= (rst || conv_done) ? 6'h0 : rises_q + {5'h0, rise};
  end
  a_conv_high: assert property (
    conv_start |=> sck_o && sdo_o && cs_pullup_en) else $error("conv");
  a_done_low: assert property (
    conv_done && sck_oe && sck_o && !frame_busy
    |=> !sck_o && !sdo_o && cs_sink_en) else $error("done");
  a_sleep_min: assert property (
    $rose(frame_busy) |-> !$past(sdo_o, 4)) else $error("sleep");
  a_first_rise: assert property (
    $rose(frame_busy) |-> (sck_oe && !sck_o) [*4] ##1 sck_o)
    else $error("rise");
  a_sdo_hold: assert property (
    frame_busy && $past(frame_busy) && !$fell(sck_o) |-> $stable(sdo_o))
    else $error("sdo");
  a_frame_end: assert property (
    $fell(frame_busy) |-> conv_start && sdo_o && sck_o && cs_pullup_en)
    else $error("end");
  a_rise_count: assert property (
    $fell(frame_busy) |-> (rises_q + {5'h0, rise}) == 6'h20)
    else $error("count");
  a_ext_idle: assert property (
    ext_mode |=> ext_mode && !frame_busy && !conv_start) else $error("ext");
  c_frame: cover property ($fell(frame_busy));
  c_ext: cover property ($rose(ext_mode));
  c_sink: cover property ($fell(cs_sink_en));
endmodule
bind adc_sck_out adc_sck_out_checker chk (
  .clk(clk), .rst(rst), .sck_o(sck_o), .sck_oe(sck_oe), .sdo_o(sdo_o),
  .cs_pullup_en(cs_pullup_en), .cs_sink_en(cs_sink_en),
  .conv_start(conv_start), .conv_done(conv_done), .ext_mode(ext_mode),
  .frame_busy(frame_busy));
`default_nettype wire

// ==== adc_sck_rx.sv ====
`timescale 1ns/1ns
`default_nettype none
module adc_sck_rx (
  input  wire logic        clk,
  input  wire logic        sck_o,
  input  wire logic        sck_oe,
  input  wire logic        sck_pullup_en,
  input  wire logic        sdo_o,
  input  wire logic        drive_low,
  input  wire logic        clr,
  output wire logic        pin,
  output logic      [31:0] word,
  output logic      [5:0]  nbits
);
  logic pin_q;
  logic sdo_q;
  // Pin level: outside driver, device drive, pull-up, else drifting
  assign pin = drive_low     ? 1'b0 :
               sck_oe        ? sck_o :
               sck_pullup_en ? 1'b1 : ~sck_o;
  // Rise seen one clock late; data taken as it stood before the rise
  always @(posedge clk) begin
    pin_q <= pin;
    sdo_q <= sdo_o;
    if (clr) begin
      word  <= 32'h0;
      nbits <= 6'h0;
    end else if (pin && !pin_q && sck_oe) begin
      word  <= {word[30:0], sdo_q};
      nbits <= nbits + 6'h1;
    end
  end
endmodule
`default_nettype wire

// ==== adc_internal_sck_serial_output_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module adc_internal_sck_serial_output_test;
  logic             clk, rst, ce, cs_low, done, drop, clr;
  logic      [30:0] word;
  wire logic        sck_o, sck_oe, sck_pu, sdo, cs_pu, sink, start, ext, busy;
  wire logic        pin;
  wire logic [31:0] got;
  wire logic [5:0]  nbits;
  int               bad_count, n_checks;
  // Result word beside the frame it should give
  logic      [62:0] rows [3] = '{{31'h7fff_ffff, 32'h7fff_ffff},
                                 {31'h0000_0000, 32'h0000_0000},
                                 {31'h2aaa_5555, 32'h2aaa_5555}};
  adc_sck_out #(.POR_CYCLES(24'h14), .SCK_HALF(8'h4)) DUT (
    .clk(clk), .rst(rst), .ce(ce), .sck_i(pin), .sck_o(sck_o),
    .sck_oe(sck_oe), .sck_pullup_en(sck_pu), .sdo_o(sdo), .cs_low_i(cs_low),
    .cs_pullup_en(cs_pu), .cs_sink_en(sink), .conv_start(start),
    .conv_done(done), .conv_word(word), .ext_mode(ext), .frame_busy(busy));
  adc_sck_rx rx (.clk(clk), .sck_o(sck_o), .sck_oe(sck_oe),
    .sck_pullup_en(sck_pu),
    .sdo_o(sdo), .drive_low(drop), .clr(clr), .pin(pin), .word(got),
    .nbits(nbits));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic tick;
    @(posedge clk);
    #2;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wait_start;
    for (int k = 0; k < 3000; k++) begin
      tick();
      if (start === 1'b1)
        return;
    end
    bad_count++;
    end_sim();
  endtask
  // One result through sleep and output frame
  task automatic convert(input logic [30:0] w, input logic [31:0] exp,
                         input logic auto);
    clr = 1'b1;
    tick();
    clr = 1'b0;
    word = w;
    done = 1'b1;
    tick();
    done = 1'b0;
    word = ~w;
    check({sck_o, sdo, sink}, 3'b001);
    if (auto) begin
      repeat (12) tick();
      check({sck_oe, sck_pu, busy, sink}, 4'b0101);
      cs_low = 1'b1;
    end
    wait_start();
    tick();
    check(got, exp);
    check({nbits, sdo, sck_o, cs_pu}, 9'h107);
  endtask
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    cs_low = 1'b1;
    done = 1'b0;
    drop = 1'b0;
    clr = 1'b0;
    word = 31'h0;
    repeat (5) tick();
    check({sck_o, sck_oe, sck_pu, sdo, busy, ext}, 6'b001100);
    rst = 1'b0;
    wait_start();
    check({sck_oe, sck_o, sdo, ext}, 4'b1110);
    // Clock enable low freezes even the start pulse
    ce = 1'b0;
    repeat (4) tick();
    check({start, sck_o, sdo}, 3'b111);
    ce = 1'b1;
    for (int i = 0; i < 3; i++) begin
      convert(rows[i][62:32], rows[i][31:0], 1'b0);
    end
    cs_low = 1'b0;
    repeat (3) tick();
    convert(31'h1234_5678, 32'h1234_5678, 1'b1);
    rst = 1'b1;
    drop = 1'b1;
    repeat (5) tick();
    rst = 1'b0;
    repeat (40) tick();
    check({ext, busy, start}, 3'b100);
    end_sim();
  end
endmodule
`default_nettype wire
